// ### rtl/posq_device.sv
// Output channel sequencer of the processor I/O section.
// Assumes the processor hands over the access word already read from U,
// and main storage answers a held read request with a one-cycle ack.
//
// Summary of operation
// - Load function copies word, enables function mode.
// - Function plus identifier: count two, consecutive.
// - Load function sets force, function, output flops.
// - Force raises simulated request for first word.
// - Function mode sends strobe with each word.
// - Function flop cleared by load output, disconnect.
// - Output active gates service; terminal, disconnect clear.
// - Function-active monitor gives function monitor interrupt.
// - Function service: test, fetch, strobe, update.
// - Subsystem latches word on strobe, drops request.
// - Subsystem then requests output, input or interrupt.
// - Function terminal: stop, no update, monitor interrupt.
// - Load output copies word, sets output active.
// - Output mode means output active, function clear.
// - Output-mode monitor gives output monitor interrupt.
// - Output request: test, fetch, acknowledge, update.
// - Subsystem takes word on acknowledge, re-requests later.
// - Output terminal: stop, no update, monitor interrupt.
// - Issuer presets count to number of words.
// - Count zero is terminal, tested first.
// - Step select: 00 increments, 10 decrements, else holds.
// - Subsystem sends one extra request to terminate.
// - Access registers sit at control addresses 060-077.
`default_nettype none

module posq_device
   import posq_pkg::*;
(
   // Clock and reset.
   input  wire logic                        core_clk_in,
   input  wire logic                        rst_b_in,
   // Channel instructions.
   input  wire logic                        instr_valid_in,
   input  wire posq_op_t                    instr_op_in,
   input  wire logic [POSQ_CHAN_W-1:0]      instr_chan_in,
   input  wire logic [POSQ_WORD_W-1:0]      instr_acw_in,
   // Main storage read path.
   output logic                             mem_req_out,
   output logic [POSQ_ADDR_W-1:0]           mem_addr_out,
   input  wire logic                        mem_ack_in,
   input  wire logic [POSQ_WORD_W-1:0]      mem_rdata_in,
   // Control register read port.
   input  wire logic [POSQ_CREG_ADDR_W-1:0] creg_addr_in,
   output logic [POSQ_WORD_W-1:0]           creg_data_out,
   output logic                             creg_hit_out,
   // Monitor interrupts.
   output logic                             func_mon_irq_out,
   output logic                             out_mon_irq_out,
   output logic [POSQ_CHAN_W-1:0]           irq_chan_out,
   // Channel lines.
   posq_if.device                           link
);

   localparam int N = POSQ_CHANNELS;

   typedef enum logic [1:0] {S_IDLE, S_TEST, S_FETCH, S_SEND} posq_state_t;

   posq_state_t              state_q;
   logic [POSQ_CHAN_W-1:0]   cur_q;
   logic                     func_q;
   logic [POSQ_WORD_W-1:0]   acr_q [N];
   logic [N-1:0]             force_q;
   logic [N-1:0]             func_act_q;
   logic [N-1:0]             out_act_q;
   logic [N-1:0]             mon_q;
   logic [N-1:0]             strobe_q;
   logic [N-1:0]             ack_q;
   logic [POSQ_WORD_W-1:0]   word_q;
   logic [POSQ_ADDR_W-1:0]   addr_q;
   logic                     func_irq_q;
   logic                     out_irq_q;
   logic [POSQ_CHAN_W-1:0]   irq_chan_q;
   logic [POSQ_WORD_W-1:0]   creg_q;
   logic                     creg_hit_q;

   // Instruction decode.
   logic             op_lf;
   logic             op_lo;
   logic             op_dc;
   logic             op_mon;
   logic [N-1:0]     hit;
   assign op_lf  = instr_op_in == POSQ_OP_LOAD_FUNCTION_CHANNEL ||
                   instr_op_in == POSQ_OP_LOAD_FUNCTION_CHANNEL_MONITORED;
   assign op_lo  = instr_op_in == POSQ_OP_LOAD_OUTPUT_CHANNEL ||
                   instr_op_in == POSQ_OP_LOAD_OUTPUT_CHANNEL_MONITORED;
   assign op_dc  = instr_op_in == POSQ_OP_DISCONNECT_OUTPUT_CHANNEL;
   assign op_mon = instr_op_in == POSQ_OP_LOAD_FUNCTION_CHANNEL_MONITORED ||
                   instr_op_in == POSQ_OP_LOAD_OUTPUT_CHANNEL_MONITORED;
   assign hit    = instr_valid_in ? (N'(1) << instr_chan_in) : '0;

   // Fields of the access word of the channel being served.
   logic [POSQ_WORD_W-1:0]  cur_acr;
   logic [POSQ_COUNT_W-1:0] cur_count;
   logic [POSQ_ADDR_W-1:0]  cur_addr;
   logic [1:0]              cur_step;
   logic [N-1:0]            cur_hot;
   logic                    terminal;
   assign cur_acr   = acr_q[cur_q];
   assign cur_count = cur_acr[POSQ_W_LSB +: POSQ_COUNT_W];
   assign cur_addr  = cur_acr[POSQ_V_LSB +: POSQ_ADDR_W];
   assign cur_step  = cur_acr[POSQ_G_LSB +: 2];
   assign cur_hot   = N'(1) << cur_q;
   assign terminal  = cur_count == '0;

   // A channel asks for service by its own request or a forced one.
   logic [N-1:0]           req;
   logic                   gnt_valid;
   logic [POSQ_CHAN_W-1:0] gnt_idx;
   logic                   take;
   assign req  = out_act_q & (link.output_data_request | force_q);
   assign take = state_q == S_IDLE && gnt_valid;

   // Only the idle sequencer takes a channel, so storage is never shared.
   posq_arb #(.N(N)) u_arb (
      .core_clk_in   (core_clk_in),
      .rst_b_in      (rst_b_in),
      .req_in        (req),
      .take_in       (take),
      .gnt_valid_out (gnt_valid),
      .gnt_idx_out   (gnt_idx)
   );

   // Terminal detection in the test cycle of a still-active channel.
   logic         term_now;
   logic [N-1:0] term_clr;
   logic [N-1:0] served_clr;
   assign term_now   = state_q == S_TEST && out_act_q[cur_q] && terminal;
   assign term_clr   = term_now ? cur_hot : '0;
   assign served_clr = (term_now || state_q == S_SEND) ? cur_hot : '0;

   // Sequencer: test, fetch, send; one word per pass.
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q <= S_IDLE;
         cur_q   <= '0;
         func_q  <= 1'b0;
         addr_q  <= '0;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (gnt_valid) begin
                  cur_q   <= gnt_idx;
                  state_q <= S_TEST;
               end
            end
            S_TEST: begin
               // A disconnect may have landed since the grant.
               if (!out_act_q[cur_q] || terminal) begin
                  state_q <= S_IDLE;
               end else begin
                  func_q  <= func_act_q[cur_q];
                  addr_q  <= cur_addr;
                  state_q <= S_FETCH;
               end
            end
            S_FETCH: begin
               if (mem_ack_in) begin
                  state_q <= S_SEND;
               end
            end
            S_SEND: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // Word lines and one-cycle strobes, all from flip-flops.
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         word_q   <= '0;
         strobe_q <= '0;
         ack_q    <= '0;
      end else begin
         strobe_q <= '0;
         ack_q    <= '0;
         if (state_q == S_FETCH && mem_ack_in) begin
            word_q <= mem_rdata_in;
            if (func_q) begin
               strobe_q <= cur_hot;
            end else begin
               ack_q <= cur_hot;
            end
         end
      end
   end

   // Access registers: a load on any channel wins over the update in that cycle.
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < N; i++) begin
            acr_q[i] <= POSQ_ACR_RESET;
         end
      end else if (instr_valid_in && (op_lf || op_lo)) begin
         acr_q[instr_chan_in] <= instr_acw_in;
      end else if (state_q == S_SEND) begin
         acr_q[cur_q][POSQ_W_LSB +: POSQ_COUNT_W] <= cur_count - 1'b1;
         if (cur_step == POSQ_STEP_INC) begin
            acr_q[cur_q][POSQ_V_LSB +: POSQ_ADDR_W] <= cur_addr + 1'b1;
         end else if (cur_step == POSQ_STEP_DEC) begin
            acr_q[cur_q][POSQ_V_LSB +: POSQ_ADDR_W] <= cur_addr - 1'b1;
         end
      end
   end

   // Channel control flops; a new instruction wins over a clear.
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         force_q    <= '0;
         func_act_q <= '0;
         out_act_q  <= '0;
         mon_q      <= '0;
      end else begin
         force_q    <= (force_q & ~served_clr & ~(hit & {N{op_lo|op_dc}}))
                       | (hit & {N{op_lf}});
         func_act_q <= (func_act_q & ~(hit & {N{op_lo | op_dc}}))
                       | (hit & {N{op_lf}});
         out_act_q  <= (out_act_q & ~term_clr & ~(hit & {N{op_dc}}))
                       | (hit & {N{op_lf | op_lo}});
         mon_q      <= (mon_q & ~term_clr & ~(hit & {N{op_lf|op_lo|op_dc}}))
                       | (hit & {N{op_mon}});
      end
   end

   // Monitor interrupt pulses; the kind follows the function flop.
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         func_irq_q <= 1'b0;
         out_irq_q  <= 1'b0;
         irq_chan_q <= '0;
      end else begin
         func_irq_q <= term_now && mon_q[cur_q] && func_act_q[cur_q];
         out_irq_q  <= term_now && mon_q[cur_q] && !func_act_q[cur_q];
         if (term_now) begin
            irq_chan_q <= cur_q;
         end
      end
   end

   // Address falls inside the access register window.
   logic creg_win;
   assign creg_win = creg_addr_in >= POSQ_ACR_BASE &&
                     creg_addr_in <= POSQ_ACR_LAST;

   // Read data is zeroed in the flop, so the port leaves a register.
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         creg_q     <= '0;
         creg_hit_q <= 1'b0;
      end else begin
         creg_hit_q <= creg_win;
         creg_q     <= creg_win ? acr_q[creg_addr_in[POSQ_CHAN_W-1:0]] : '0;
      end
   end

   assign mem_req_out              = state_q == S_FETCH;
   assign mem_addr_out             = addr_q;
   assign link.function_strobe     = strobe_q;
   assign link.output_acknowledge  = ack_q;
   assign link.output_word         = word_q;
   assign func_mon_irq_out         = func_irq_q;
   assign out_mon_irq_out          = out_irq_q;
   assign irq_chan_out             = irq_chan_q;
   assign creg_hit_out             = creg_hit_q;
   assign creg_data_out            = creg_q;
endmodule : posq_device

`default_nettype wire

// ### pkg/posq_pkg.sv
// Shared constants and types for the parallel output channel sequencer.
// Assumes both ends and the bench run on one clock and import this package.
`default_nettype none

package posq_pkg;

   // Channel and word geometry.
   localparam int POSQ_CHANNELS = 16;
   localparam int POSQ_CHAN_W   = 4;
   localparam int POSQ_WORD_W   = 36;
   localparam int POSQ_ADDR_W   = 18;
   localparam int POSQ_COUNT_W  = 16;

   // Field positions inside an output access word.
   localparam int POSQ_V_LSB = 0;
   localparam int POSQ_W_LSB = 18;
   localparam int POSQ_G_LSB = 34;

   // Step-select encodings; the two others leave the address alone.
   localparam logic [1:0] POSQ_STEP_INC = 2'h0;
   localparam logic [1:0] POSQ_STEP_DEC = 2'h2;

   // Control register addresses of the output access registers.
   localparam int               POSQ_CREG_ADDR_W = 7;
   localparam logic [6:0]       POSQ_ACR_BASE    = 7'h30;
   localparam logic [6:0]       POSQ_ACR_LAST    = 7'h3f;

   // Reset value of every output access register.
   localparam logic [35:0] POSQ_ACR_RESET = 36'h0;

   // Channel instructions issued by the processor.
   typedef enum logic [2:0] {
      POSQ_OP_NONE,
      POSQ_OP_LOAD_FUNCTION_CHANNEL,
      POSQ_OP_LOAD_FUNCTION_CHANNEL_MONITORED,
      POSQ_OP_LOAD_OUTPUT_CHANNEL,
      POSQ_OP_LOAD_OUTPUT_CHANNEL_MONITORED,
      POSQ_OP_DISCONNECT_OUTPUT_CHANNEL
   } posq_op_t;

endpackage : posq_pkg

`default_nettype wire

// ### pkg/posq_if.sv
// Word-parallel output channel lines between the sequencer and a subsystem.
// Assumes both parties share the one clock; no pin synchronisation needed.
`default_nettype none

interface posq_if;
   import posq_pkg::*;

   logic [POSQ_CHANNELS-1:0] output_data_request;
   logic [POSQ_CHANNELS-1:0] function_strobe;
   logic [POSQ_CHANNELS-1:0] output_acknowledge;
   logic [POSQ_WORD_W-1:0]   output_word;

   modport device (
      input  output_data_request,
      output function_strobe,
      output output_acknowledge,
      output output_word
   );

   modport subsystem (
      output output_data_request,
      input  function_strobe,
      input  output_acknowledge,
      input  output_word
   );
endinterface : posq_if

`default_nettype wire

// ### rtl/posq_arb.sv
// Round-robin picker of one requesting channel.
// Assumes the caller pulses take_in only in a cycle where a grant is valid.
`default_nettype none

module posq_arb
   import posq_pkg::*;
#(
   parameter int N = POSQ_CHANNELS
) (
   // Clock and reset.
   input  wire logic                   core_clk_in,
   input  wire logic                   rst_b_in,
   // Requests and grant.
   input  wire logic [N-1:0]           req_in,
   input  wire logic                   take_in,
   output logic                        gnt_valid_out,
   output logic [POSQ_CHAN_W-1:0]      gnt_idx_out
);

   // The index width is fixed by the channel field of the instructions.
   if (N < 2 || N > (1 << POSQ_CHAN_W)) begin : g_bad_n
      $error("posq_arb: N out of range");
   end

   logic [POSQ_CHAN_W-1:0] last_q;

   // Search starts just after the last winner so no channel starves.
   always_comb begin
      logic [POSQ_CHAN_W-1:0] idx;
      idx           = '0;
      gnt_valid_out = 1'b0;
      gnt_idx_out   = '0;
      for (int i = N; i >= 1; i--) begin
         idx = POSQ_CHAN_W'((int'(last_q) + i) % N);
         if (req_in[idx]) begin
            gnt_valid_out = 1'b1;
            gnt_idx_out   = idx;
         end
      end
   end

   // Remember the winner once the sequence is actually started.
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         last_q <= POSQ_CHAN_W'(N - 1);
      end else if (take_in && gnt_valid_out) begin
         last_q <= gnt_idx_out;
      end
   end
endmodule : posq_arb

`default_nettype wire

// ### rtl/posq_subsystem.sv
// Peripheral subsystem end of the word-parallel output channel.
// Assumes the user pulses or holds ready_in when it wants another word.
`default_nettype none

module posq_subsystem
   import posq_pkg::*;
(
   // Clock and reset.
   input  wire logic                    core_clk_in,
   input  wire logic                    rst_b_in,
   // User side.
   input  wire logic [POSQ_CHANNELS-1:0] ready_in,
   output logic [POSQ_CHANNELS-1:0]      odr_pending_out,
   output logic                          rx_valid_out,
   output logic                          rx_is_function_out,
   output logic [POSQ_CHAN_W-1:0]        rx_chan_out,
   output logic [POSQ_WORD_W-1:0]        rx_word_out,
   // Channel lines.
   posq_if.subsystem                     link
);

   logic [POSQ_CHANNELS-1:0] odr_q;
   logic [POSQ_CHANNELS-1:0] taken;
   assign taken = link.function_strobe | link.output_acknowledge;

   // Per channel request flop; a received word drops it first.
   for (genvar c = 0; c < POSQ_CHANNELS; c++) begin : g_chan
      always_ff @(posedge core_clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            odr_q[c] <= 1'b0;
         end else if (taken[c]) begin
            odr_q[c] <= 1'b0;
         end else if (ready_in[c]) begin
            odr_q[c] <= 1'b1;
         end
      end
   end

   // Latch the word into the control section when it is strobed or acknowledged in.
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_valid_out       <= 1'b0;
         rx_is_function_out <= 1'b0;
         rx_chan_out        <= '0;
         rx_word_out        <= '0;
      end else begin
         rx_valid_out <= |taken;
         if (|taken) begin
            rx_word_out        <= link.output_word;
            rx_is_function_out <= |link.function_strobe;
            for (int i = 0; i < POSQ_CHANNELS; i++) begin
               if (taken[i]) begin
                  rx_chan_out <= POSQ_CHAN_W'(i);
               end
            end
         end
      end
   end

   assign link.output_data_request = odr_q;
   assign odr_pending_out          = odr_q;
endmodule : posq_subsystem

`default_nettype wire

// ### tb/posq_link_asserts.sv
// Concurrent checks on the word-parallel link between the two ends.
// Assumes the bench top instantiates it beside the interface instance.
`default_nettype none

module posq_link_asserts
   import posq_pkg::*;
(
   // Clock and reset.
   input  wire logic                     core_clk_in,
   input  wire logic                     rst_b_in,
   // Link lines.
   input  wire logic [POSQ_CHANNELS-1:0] output_data_request,
   input  wire logic [POSQ_CHANNELS-1:0] function_strobe,
   input  wire logic [POSQ_CHANNELS-1:0] output_acknowledge,
   input  wire logic [POSQ_WORD_W-1:0]   output_word
);
   timeunit 1ns;
   timeprecision 1ns;

   // One domain, so clock and reset are given once for every check.
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   // Any word transfer on any channel, strobe or acknowledge.
   wire logic [POSQ_CHANNELS-1:0] pulse = function_strobe | output_acknowledge;

   // A service takes grant, test and fetch before the next send.
   sequence s_word;
      pulse != '0;
   endsequence
   sequence s_quiet;
      (pulse == '0) [*3];
   endsequence

   property p_one_word;
      $onehot0(pulse);
   endproperty
   property p_kind_excl;
      (function_strobe & output_acknowledge) == '0;
   endproperty
   property p_spacing;
      s_word |=> s_quiet;
   endproperty
   property p_ack_odr;
      (output_acknowledge & ~output_data_request) == '0;
   endproperty
   property p_ack_held;
      output_acknowledge != '0 |->
         (output_acknowledge & $past(output_data_request, 3))
            == output_acknowledge;
   endproperty
   property p_ack_drop;
      output_acknowledge != '0 |=>
         (output_data_request & $past(output_acknowledge)) == '0;
   endproperty
   property p_strobe_drop;
      function_strobe != '0 |=>
         (output_data_request & $past(function_strobe)) == '0;
   endproperty
   property p_word_hold;
      $changed(output_word) |-> s_word;
   endproperty

   a_one_word: assert property (p_one_word)
      else $error("more than one word sent in a cycle");
   a_kind_excl: assert property (p_kind_excl)
      else $error("strobe and acknowledge on one channel together");
   a_spacing: assert property (p_spacing)
      else $error("next word sent too soon after a word");
   a_ack_odr: assert property (p_ack_odr)
      else $error("acknowledge without a pending request");
   a_ack_held: assert property (p_ack_held)
      else $error("acknowledge without request at grant time");
   a_ack_drop: assert property (p_ack_drop)
      else $error("request not dropped after acknowledge");
   a_strobe_drop: assert property (p_strobe_drop)
      else $error("request not dropped after function strobe");
   a_word_hold: assert property (p_word_hold)
      else $error("output word changed without a transfer pulse");
endmodule : posq_link_asserts

`default_nettype wire

// ### tb/parallel_output_channel_sequencer_tb_top.sv
// Bench joining sequencer and subsystem over the link interface.
// Assumes a random-latency storage model; expectations kept in a queue.
`default_nettype none

module parallel_output_channel_sequencer_tb_top
   import posq_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic [1:0]             kind;
      logic [POSQ_CHAN_W-1:0] chan;
      logic [POSQ_WORD_W-1:0] word;
   } posq_note_t;

   logic                        core_clk;
   logic                        rst_b;
   logic                        instr_valid;
   posq_op_t                    instr_op;
   logic [POSQ_CHAN_W-1:0]      instr_chan;
   logic [POSQ_WORD_W-1:0]      instr_acw;
   logic                        mem_req;
   logic [POSQ_ADDR_W-1:0]      mem_addr;
   logic                        mem_ack;
   logic [POSQ_WORD_W-1:0]      mem_rdata;
   logic [POSQ_CREG_ADDR_W-1:0] creg_addr;
   logic [POSQ_WORD_W-1:0]      creg_data;
   logic                        creg_hit;
   logic                        func_irq;
   logic                        out_irq;
   logic [POSQ_CHAN_W-1:0]      irq_chan;
   logic [POSQ_CHANNELS-1:0]    ready;
   logic                        rx_valid;
   logic                        rx_func;
   logic [POSQ_CHAN_W-1:0]      rx_chan;
   logic [POSQ_WORD_W-1:0]      rx_word;
   logic [POSQ_WORD_W-1:0]      exp_acr [POSQ_CHANNELS];
   integer                      seed = 32'h0460e42d;
   int                          num_errors;
   int                          comparisons;
   posq_note_t                  notes [$];

   posq_if link_if ();

   posq_device u_posq_device (
      .core_clk_in (core_clk), .rst_b_in (rst_b),
      .instr_valid_in (instr_valid), .instr_op_in (instr_op),
      .instr_chan_in (instr_chan), .instr_acw_in (instr_acw),
      .mem_req_out (mem_req), .mem_addr_out (mem_addr),
      .mem_ack_in (mem_ack), .mem_rdata_in (mem_rdata),
      .creg_addr_in (creg_addr), .creg_data_out (creg_data),
      .creg_hit_out (creg_hit), .func_mon_irq_out (func_irq),
      .out_mon_irq_out (out_irq), .irq_chan_out (irq_chan),
      .link (link_if));

   posq_subsystem u_posq_subsystem (
      .core_clk_in (core_clk), .rst_b_in (rst_b), .ready_in (ready),
      .odr_pending_out (), .rx_valid_out (rx_valid),
      .rx_is_function_out (rx_func), .rx_chan_out (rx_chan),
      .rx_word_out (rx_word), .link (link_if));

   posq_link_asserts u_posq_link_asserts (
      .core_clk_in (core_clk), .rst_b_in (rst_b),
      .output_data_request (link_if.output_data_request),
      .function_strobe (link_if.function_strobe),
      .output_acknowledge (link_if.output_acknowledge),
      .output_word (link_if.output_word));

   // Storage contents are a pattern derived from the address.
   function automatic logic [35:0] mem_word(input logic [17:0] a);
      return {~a, a};
   endfunction : mem_word

   task automatic summarize;
      $display("counts: %0d comparisons, %0d errors", comparisons,
               num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize

   // Every observed event must match the oldest note, in order.
   task automatic check_note(input posq_note_t seen);
      posq_note_t want;
      comparisons++;
      if (notes.size() == 0) begin
         num_errors++;
         $display("CHECK FAILED link_event expected none seen %h", seen);
      end else begin
         want = notes.pop_front();
         if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED link_event expected %h seen %h", want,
                     seen);
         end
      end
   endtask : check_note

   task automatic issue(input posq_op_t op, input logic [3:0] ch,
                        input logic [35:0] acw);
      instr_valid = 1'b1;
      instr_op    = op;
      instr_chan  = ch;
      instr_acw   = acw;
      @(negedge core_clk);
      instr_valid = 1'b0;
      @(negedge core_clk);
   endtask : issue

   // Bounded wait for all notes, then a quiet spell for stray events.
   task automatic drain(input int id);
      for (int n = 0; n < 600 && notes.size() != 0; n++)
         @(negedge core_clk);
      repeat (20) @(negedge core_clk);
      comparisons++;
      if (notes.size() != 0) begin
         num_errors++;
         $display("CHECK FAILED pending_notes expected 0 seen %0d",
                  notes.size());
      end
      $display("test %0d done", id);
   endtask : drain

   // Loads a channel, notes each word then the optional interrupt.
   task automatic run(input int id, input posq_op_t op,
                      input logic [3:0] ch, input logic [1:0] g,
                      input logic [15:0] w);
      logic [17:0] v;
      logic [17:0] v0;
      logic        fn;
      int          k;
      v0 = 18'($random(seed));
      v  = v0;
      fn = op inside {POSQ_OP_LOAD_FUNCTION_CHANNEL,
                      POSQ_OP_LOAD_FUNCTION_CHANNEL_MONITORED};
      for (int i = 0; i < w; i++) begin
         notes.push_back({fn ? 2'h0 : 2'h1, ch, mem_word(v)});
         if (g == POSQ_STEP_INC) v = v + 18'h1;
         else if (g == POSQ_STEP_DEC) v = v - 18'h1;
      end
      if (op inside {POSQ_OP_LOAD_FUNCTION_CHANNEL_MONITORED,
                     POSQ_OP_LOAD_OUTPUT_CHANNEL_MONITORED})
         notes.push_back({fn ? 2'h2 : 2'h3, ch, 36'h0});
      exp_acr[ch] = {g, 16'h0, v};
      k           = notes.size();
      // Function runs hold the request low so the first word is forced.
      ready       = POSQ_CHANNELS'($random(seed));
      ready[ch]   = !fn;
      issue(op, ch, {g, w, v0});
      if (fn && k != 0) begin
         for (int n = 0; n < 100 && notes.size() == k; n++)
            @(negedge core_clk);
         comparisons++;
         if (notes.size() == k) begin
            num_errors++;
            $display("CHECK FAILED forced_word expected %0d seen %0d",
                     k - 1, notes.size());
         end
      end
      ready[ch]   = 1'b1;
      drain(id);
   endtask : run

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Storage acknowledges a held read after a random wait.
   always @(negedge core_clk) begin
      mem_ack   <= mem_req && !mem_ack && (($random(seed) & 1) == 0);
      mem_rdata <= mem_word(mem_addr);
   end

   // Results are compared where registered outputs have settled.
   always @(negedge core_clk) begin
      if (rx_valid === 1'b1)
         check_note({rx_func ? 2'h0 : 2'h1, rx_chan, rx_word});
      if (func_irq === 1'b1) check_note({2'h2, irq_chan, 36'h0});
      if (out_irq === 1'b1) check_note({2'h3, irq_chan, 36'h0});
   end

   // A hang ends the run through the same verdict.
   initial begin
      #300000;
      num_errors++;
      $display("CHECK FAILED watchdog expected finish seen timeout");
      summarize();
   end

   initial begin
      logic hit;
      rst_b       = 1'b0;
      instr_valid = 1'b0;
      instr_op    = POSQ_OP_NONE;
      instr_chan  = 4'h0;
      instr_acw   = 36'h0;
      creg_addr   = 7'h0;
      ready       = 16'h0;
      for (int c = 0; c < POSQ_CHANNELS; c++) exp_acr[c] = POSQ_ACR_RESET;
      repeat (16) @(posedge core_clk);
      @(negedge core_clk);
      rst_b = 1'b1;
      // Disconnect before any request: no word and no interrupt.
      issue(POSQ_OP_LOAD_OUTPUT_CHANNEL_MONITORED, 4'h1, 36'h0);
      issue(POSQ_OP_DISCONNECT_OUTPUT_CHANNEL, 4'h1, 36'h0);
      ready[1] = 1'b1;
      drain(0);
      run(1, POSQ_OP_LOAD_FUNCTION_CHANNEL, 4'h3, 2'h0, 16'h2);
      run(2, POSQ_OP_LOAD_FUNCTION_CHANNEL_MONITORED, 4'h5, 2'h2,
          16'h2);
      run(3, POSQ_OP_LOAD_OUTPUT_CHANNEL, 4'h5, 2'h1, 16'h3);
      run(4, POSQ_OP_LOAD_OUTPUT_CHANNEL_MONITORED, 4'h7, 2'h3,
          16'h4);
      run(5, POSQ_OP_LOAD_FUNCTION_CHANNEL_MONITORED, 4'h0, 2'h0,
          16'h0);
      run(6, POSQ_OP_LOAD_OUTPUT_CHANNEL_MONITORED, 4'hf, 2'h0,
          16'h0);
      run(7, POSQ_OP_LOAD_FUNCTION_CHANNEL, 4'h2, 2'h0, 16'h1);
      // Access registers read back around both ends of their range.
      for (int a = 'h2e; a <= 'h41; a++) begin
         creg_addr = a[6:0];
         @(negedge core_clk);
         hit = (a >= POSQ_ACR_BASE) && (a <= POSQ_ACR_LAST);
         comparisons++;
         if (creg_hit !== hit || creg_data !==
             (hit ? exp_acr[a - POSQ_ACR_BASE] : 36'h0)) begin
            num_errors++;
            $display("CHECK FAILED creg_%h expected %h seen %h", a,
                     hit ? exp_acr[a - POSQ_ACR_BASE] : 36'h0, creg_data);
         end
      end
      $display("test 8 done");
      summarize();
   end
endmodule : parallel_output_channel_sequencer_tb_top

`default_nettype wire
